/* File: tmr_timer0.sv */
// Functional notes
// - Interrupt control bits: enables 7..3, timer, pin, port flags 2..0.
// - Interrupt control reachable at four mirrored bank addresses.
// - Flags set on their events regardless of any enable bit.
// - Every interrupt control bit is readable and writable.
// - Reset: option all ones, control bits 7..1 zero.
// - Option bits: pull-up, edge select, source, source edge, assign, ratio.
// - Source edge 1 counts falling pin edges, 0 counts rising.
// - Assignment 1 routes prescaler to watchdog, 0 to timer.
// - Ratio codes give timer 1:2..1:256, watchdog 1:1..1:128.
// - One prescaler; the unassigned unit runs undivided.
// - Prescaler count has no register address.
// - Timer write clears prescaler count while assigned to timer.
// - That clearing write leaves assignment and ratio unchanged.
// - Watchdog clear clears prescaler when assigned to watchdog.
// - Unassigned prescaler: external clock passes straight to synchroniser.
// - Prescaler output sampled on phases Q2 and Q4.
`include "tmr_defs.svh"

module tmr_timer0 (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [8:0] addr,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    input  wire logic       watchdog_clear_instr,
    input  wire logic       upper_port_read,
    input  wire logic       timer_ext_clk_pin,
    input  wire logic       ext_int_pin,
    input  wire logic [3:0] upper_port,
    output logic            port_pullup_disable,
    output logic            watchdog_tick,
    output logic            irq
);

    function automatic logic is_irq_addr(input logic [8:0] a);
        is_irq_addr = (a == `TMR_ADDR_IRQ_B0) || (a == `TMR_ADDR_IRQ_B1) ||
                      (a == `TMR_ADDR_IRQ_B2) || (a == `TMR_ADDR_IRQ_B3);
    endfunction : is_irq_addr

    tmr_pkg::tmr_byte_t option_q;
    tmr_pkg::tmr_byte_t interrupt_control_q;
    tmr_pkg::tmr_byte_t timer_count_q;
    tmr_pkg::tmr_phase_e phase_q;
    logic [7:0] presc_q;
    logic [2:0] tclk_sync_q;
    logic       samp_q;
    logic [2:0] ext_sync_q;
    logic [3:0] port_s1_q;
    logic [3:0] port_s2_q;
    logic [3:0] port_latch_q;
    logic       presc_out;
    logic       presc_out_q;
    logic       src_edge;
    logic       tick_in;
    logic       tmr_inc;
    logic       ovf_evt;
    logic       ext_evt;
    logic       pc_evt;
    logic       wr_count;
    logic       wr_irq;
    logic       wr_opt;
    logic       psa_wdt;
    logic [7:0] ratio_mask;
    logic       presc_clr;
    logic       instr_tick;

    assign psa_wdt  = option_q[`TMR_OP_PSA];
    assign wr_count = wr_en && (addr == `TMR_ADDR_COUNT ||
                                addr == `TMR_ADDR_COUNT_B0);
    assign wr_opt   = wr_en && (addr == `TMR_ADDR_OPTION ||
                                addr == `TMR_ADDR_OPTION_B1);
    assign wr_irq   = wr_en && is_irq_addr(addr);
    assign port_pullup_disable = option_q[`TMR_OP_PULLUP];

    // Instruction cycle is four phases
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase_q <= tmr_pkg::TMR_Q1;
        end else begin
            case (phase_q)
                tmr_pkg::TMR_Q1: phase_q <= tmr_pkg::TMR_Q2;
                tmr_pkg::TMR_Q2: phase_q <= tmr_pkg::TMR_Q3;
                tmr_pkg::TMR_Q3: phase_q <= tmr_pkg::TMR_Q4;
                default:         phase_q <= tmr_pkg::TMR_Q1;
            endcase
        end
    end
    assign instr_tick = (phase_q == tmr_pkg::TMR_Q4);

    // Pin synchronisers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tclk_sync_q <= 3'h0;
            ext_sync_q  <= 3'h0;
            port_s1_q   <= 4'h0;
            port_s2_q   <= 4'h0;
        end else begin
            tclk_sync_q <= {tclk_sync_q[1:0], timer_ext_clk_pin};
            ext_sync_q  <= {ext_sync_q[1:0], ext_int_pin};
            port_s1_q   <= upper_port;
            port_s2_q   <= port_s1_q;
        end
    end

    // Counted edge of synchronised timer clock pin
    assign src_edge = option_q[`TMR_OP_SE] ?
                      (tclk_sync_q[2] && !tclk_sync_q[1]) :
                      (!tclk_sync_q[2] && tclk_sync_q[1]);
    assign tick_in  = option_q[`TMR_OP_CS] ? src_edge : instr_tick;

    // Shared prescaler; count is never visible on the bus
    assign presc_clr = (wr_count && !psa_wdt) ||
                       (watchdog_clear_instr && psa_wdt);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            presc_q <= 8'h00;
        end else if (presc_clr) begin
            presc_q <= 8'h00;
        end else if (psa_wdt ? instr_tick : tick_in) begin
            presc_q <= presc_q + 8'h01;
        end
    end

    // Ratio mask: timer 2^(n+1), watchdog 2^n
    always_comb begin
        ratio_mask = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i <= int'(option_q[`TMR_OP_PS_HI:`TMR_OP_PS_LO]))
                ratio_mask[i] = 1'b1;
        end
        if (psa_wdt)
            ratio_mask = ratio_mask >> 1;
    end

    // Divided output: bit selected by ratio toggles
    always_comb begin
        presc_out = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (ratio_mask[i] && !ratio_mask[(i + 1) % 8])
                presc_out = presc_q[i];
            if (i == 7 && ratio_mask[7])
                presc_out = presc_q[7];
        end
    end

    // Unassigned: pin level, or a toggle per instruction cycle
    logic tmr_src;
    assign tmr_src = option_q[`TMR_OP_CS] ? tclk_sync_q[1]
                                          : (samp_q ^ instr_tick);
    assign watchdog_tick = psa_wdt ?
        (ratio_mask == 8'h00 ? instr_tick
                             : (presc_out && !presc_out_q))
        : instr_tick;

    // Sample prescaler output on Q2 and Q4
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            samp_q <= 1'b0;
        end else if (phase_q == tmr_pkg::TMR_Q2 ||
                     phase_q == tmr_pkg::TMR_Q4) begin
            samp_q <= psa_wdt ? tmr_src : presc_out;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            presc_out_q <= 1'b0;
        end else begin
            presc_out_q <= presc_out;
        end
    end

    logic samp_prev_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            samp_prev_q <= 1'b0;
        end else begin
            samp_prev_q <= samp_q;
        end
    end
    // Pin level counts on the selected edge; internal toggle on any change
    assign tmr_inc = !psa_wdt ? (samp_q && !samp_prev_q) :
                     !option_q[`TMR_OP_CS] ? (samp_q != samp_prev_q) :
                     option_q[`TMR_OP_SE] ? (!samp_q && samp_prev_q) :
                     (samp_q && !samp_prev_q);

    // Timer count register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            timer_count_q <= 8'h00;
        end else if (wr_count) begin
            timer_count_q <= wr_data;
        end else if (tmr_inc) begin
            timer_count_q <= timer_count_q + 8'h01;
        end
    end
    assign ovf_evt = tmr_inc && !wr_count &&
                     (timer_count_q == 8'hff);

    // Option register; a timer write never touches it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            option_q <= `TMR_OPTION_RST;
        end else if (wr_opt) begin
            option_q <= wr_data;
        end
    end

    // External pin and port change events
    assign ext_evt = option_q[`TMR_OP_EXTEDG] ?
                     (ext_sync_q[1] && !ext_sync_q[2]) :
                     (!ext_sync_q[1] && ext_sync_q[2]);
    assign pc_evt  = (port_s2_q != port_latch_q);

    // Port read takes a new reference, ending the mismatch
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            port_latch_q <= 4'h0;
        end else if (upper_port_read) begin
            port_latch_q <= port_s2_q;
        end
    end

    // Interrupt control: events win over a software clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            interrupt_control_q <= `TMR_IRQ_RST;
        end else begin
            if (wr_irq)
                interrupt_control_q <= wr_data;
            if (ovf_evt)
                interrupt_control_q[`TMR_IC_TOF] <= 1'b1;
            if (ext_evt)
                interrupt_control_q[`TMR_IC_EXTF] <= 1'b1;
            if (pc_evt)
                interrupt_control_q[`TMR_IC_PCF] <= 1'b1;
        end
    end

    assign irq = interrupt_control_q[`TMR_IC_GIE] &&
        ((interrupt_control_q[`TMR_IC_TOIE] && interrupt_control_q[`TMR_IC_TOF]) ||
         (interrupt_control_q[`TMR_IC_EXTIE] && interrupt_control_q[`TMR_IC_EXTF]) ||
         (interrupt_control_q[`TMR_IC_PCIE] && interrupt_control_q[`TMR_IC_PCF]));

    // Read mux registered
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            if (addr == `TMR_ADDR_COUNT || addr == `TMR_ADDR_COUNT_B0)
                rd_data <= timer_count_q;
            else if (wr_opt || addr == `TMR_ADDR_OPTION ||
                     addr == `TMR_ADDR_OPTION_B1)
                rd_data <= option_q;
            else if (is_irq_addr(addr))
                rd_data <= interrupt_control_q;
            else
                rd_data <= 8'h00;
        end
    end

    overflow_flag_a: assert property (@(posedge clk)
        disable iff (!rst_b) ovf_evt |=> interrupt_control_q[`TMR_IC_TOF])
        else $error("overflow did not set flag");

    reset_option_a: assert property (@(posedge clk)
        !rst_b |=> option_q == `TMR_OPTION_RST && interrupt_control_q[7:1] == 7'h00)
        else $error("reset values wrong");

    ext_flag_a: assert property (@(posedge clk)
        disable iff (!rst_b) ext_evt |=> interrupt_control_q[`TMR_IC_EXTF])
        else $error("pin event lost");

    presc_clear_a: assert property (@(posedge clk)
        disable iff (!rst_b) (wr_count && !psa_wdt) |=> presc_q == 8'h00)
        else $error("timer write left prescaler count");

    wdt_clear_a: assert property (@(posedge clk)
        disable iff (!rst_b)
        (watchdog_clear_instr && psa_wdt) |=> presc_q == 8'h00)
        else $error("watchdog clear left prescaler count");

    option_keep_a: assert property (@(posedge clk)
        disable iff (!rst_b) (wr_count && !wr_opt) |=> $stable(option_q))
        else $error("timer write changed option");

    mirror_read_a: assert property (@(posedge clk)
        disable iff (!rst_b)
        (rd_en && is_irq_addr(addr)) |=> rd_data == $past(interrupt_control_q))
        else $error("mirror read mismatch");

    count_write_a: assert property (@(posedge clk)
        disable iff (!rst_b) wr_count |=> timer_count_q == $past(wr_data))
        else $error("timer write not stored");

    sample_phase_a: assert property (@(posedge clk)
        disable iff (!rst_b)
        (phase_q == tmr_pkg::TMR_Q1 || phase_q == tmr_pkg::TMR_Q3)
        |=> $stable(samp_q))
        else $error("sample outside Q2 or Q4");

    port_flag_a: assert property (@(posedge clk)
        disable iff (!rst_b) pc_evt |=> interrupt_control_q[`TMR_IC_PCF])
        else $error("port change lost");

    ovf_wrap_a: assert property (@(posedge clk)
        disable iff (!rst_b) ovf_evt |=> timer_count_q == 8'h00)
        else $error("overflow did not wrap to zero");

    count_inc_a: assert property (@(posedge clk)
        disable iff (!rst_b) (tmr_inc && !wr_count)
        |=> timer_count_q == $past(timer_count_q) + 8'h01)
        else $error("timer did not advance");

    count_hold_a: assert property (@(posedge clk)
        disable iff (!rst_b) (!tmr_inc && !wr_count)
        |=> $stable(timer_count_q))
        else $error("timer moved without a tick");

    option_write_a: assert property (@(posedge clk)
        disable iff (!rst_b) wr_opt |=> option_q == $past(wr_data))
        else $error("option write not stored");

    irq_write_a: assert property (@(posedge clk)
        disable iff (!rst_b) (wr_irq && !ovf_evt && !ext_evt && !pc_evt)
        |=> interrupt_control_q == $past(wr_data))
        else $error("control write not stored");

    ovf_hold_a: assert property (@(posedge clk)
        disable iff (!rst_b) (!wr_irq && interrupt_control_q[`TMR_IC_TOF])
        |=> interrupt_control_q[`TMR_IC_TOF])
        else $error("overflow flag dropped");

    ext_hold_a: assert property (@(posedge clk)
        disable iff (!rst_b) (!wr_irq && interrupt_control_q[`TMR_IC_EXTF])
        |=> interrupt_control_q[`TMR_IC_EXTF])
        else $error("pin flag dropped");

    port_ref_a: assert property (@(posedge clk)
        disable iff (!rst_b)
        upper_port_read |=> port_latch_q == $past(port_s2_q))
        else $error("port reference not taken");

    phase_wrap_a: assert property (@(posedge clk)
        disable iff (!rst_b) phase_q == tmr_pkg::TMR_Q4 |=> instr_tick == 1'b0)
        else $error("phase did not wrap");

    inc_pulse_a: assert property (@(posedge clk)
        disable iff (!rst_b) tmr_inc |=> !tmr_inc)
        else $error("timer increment longer than one cycle");

endmodule : tmr_timer0

/* File: tmr_defs.svh */
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// Register addresses (9-bit data memory address)
`define TMR_ADDR_COUNT      9'h101
`define TMR_ADDR_COUNT_B0   9'h001
`define TMR_ADDR_OPTION     9'h181
`define TMR_ADDR_OPTION_B1  9'h081
`define TMR_ADDR_IRQ_B0     9'h00b
`define TMR_ADDR_IRQ_B1     9'h08b
`define TMR_ADDR_IRQ_B2     9'h10b
`define TMR_ADDR_IRQ_B3     9'h18b

// Interrupt control bit positions
`define TMR_IC_GIE     7
`define TMR_IC_PERIPH_IRQ_ENABLE    6
`define TMR_IC_TOIE    5
`define TMR_IC_EXTIE   4
`define TMR_IC_PCIE    3
`define TMR_IC_TOF     2
`define TMR_IC_EXTF    1
`define TMR_IC_PCF     0

// Option bit positions
`define TMR_OP_PULLUP  7
`define TMR_OP_EXTEDG  6
`define TMR_OP_CS      5
`define TMR_OP_SE      4
`define TMR_OP_PSA     3
`define TMR_OP_PS_HI   2
`define TMR_OP_PS_LO   0

// Reset values
`define TMR_OPTION_RST 8'hff
`define TMR_IRQ_RST    8'h00

// Index of the last phase clock in an instruction cycle
`define TMR_PHASES     2'h3

`endif

/* File: tmr_pkg.sv */
package tmr_pkg;
    typedef enum logic [1:0] {
        TMR_Q1,
        TMR_Q2,
        TMR_Q3,
        TMR_Q4
    } tmr_phase_e;
    typedef logic [7:0] tmr_byte_t;
endpackage : tmr_pkg

/* File: tmr_pins_model.sv */
module tmr_pins_model (
    input  wire logic       clk,
    output logic            ext_clk,
    output logic            int_pin,
    output logic      [3:0] port
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ext_clk = 1'b0;
        int_pin = 1'b0;
        port    = 4'h0;
    end

    // New pin levels, then a hold far beyond two oscillator periods
    task automatic drive(input logic c, input logic i, input logic [3:0] p);
        @(posedge clk);
        ext_clk <= c;
        int_pin <= i;
        port    <= p;
        repeat (12) @(posedge clk);
    endtask : drive
endmodule : tmr_pins_model

/* File: tmr_timer0_tb.sv */
module tmr_timer0_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk     = 1'b0;
    logic       rst_b   = 1'b0;
    logic       wr_en   = 1'b0;
    logic       rd_en   = 1'b0;
    logic       wd_clr  = 1'b0;
    logic       port_rd = 1'b0;
    logic [8:0] addr    = 9'h000;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data;
    logic [7:0] v;
    logic [3:0] port;
    logic       ext_clk, int_pin, ppd, wd_tick, irq;
    int         bad_count = 0;
    int         tests_run = 0;
    int         ticks     = 0;
    int         e;

    always #2.5 clk = ~clk;
    always @(posedge clk) if (wd_tick === 1'b1) ticks <= ticks + 1;

    tmr_pins_model tmr_pins_model_i (.clk(clk), .ext_clk(ext_clk),
        .int_pin(int_pin), .port(port));

    tmr_timer0 tmr_timer0_i (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data),
        .rd_data(rd_data), .watchdog_clear_instr(wd_clr),
        .upper_port_read(port_rd), .timer_ext_clk_pin(ext_clk),
        .ext_int_pin(int_pin), .upper_port(port),
        .port_pullup_disable(ppd), .watchdog_tick(wd_tick), .irq(irq));

    task automatic check(input string n, input logic [7:0] s, x);
        tests_run++;
        if (s !== x) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask : check

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        #1 v = rd_data;
    endtask : rd

    task automatic give_verdict;
        if (bad_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic t_reset;
        rd(9'h181);
        check("option", v, 8'hff);
        rd(9'h10b);
        check("interrupt_control", v & 8'hfe, 8'h00);
        check("pullup", {7'h00, ppd}, 8'h01);
    endtask : t_reset

    task automatic t_regs;
        logic [8:0] m[4] = '{9'h00b, 9'h08b, 9'h10b, 9'h18b};
        wr(9'h00b, 8'hf8);
        foreach (m[k]) begin
            rd(m[k]);
            check("mirror", v, 8'hf8);
        end
        wr(9'h08b, 8'h07);
        rd(9'h18b);
        check("flags rw", v, 8'h07);
        rd(9'h105);
        check("unmapped", v, 8'h00);
        wr(9'h10b, 8'h00);
    endtask : t_regs

    task automatic t_ovf;
        wr(9'h081, 8'h08);
        rd(9'h181);
        check("option", v, 8'h08);
        check("pullup", {7'h00, ppd}, 8'h00);
        wr(9'h101, 8'hfd);
        repeat (40) @(posedge clk);
        rd(9'h10b);
        check("ovf flag", v & 8'h04, 8'h04);
        rd(9'h10b);
        check("ovf held", v & 8'h04, 8'h04);
        wr(9'h10b, 8'h00);
    endtask : t_ovf

    task automatic t_presc;
        for (int c = 0; c < 3; c++) begin
            wr(9'h181, 8'(c));
            wr(9'h101, 8'h00);
            repeat (160) @(posedge clk);
            rd(9'h101);
            e = 160 >> (c + 3);
            check("ratio", 8'(v >= e - 1 && v <= e + 1), 8'h01);
            rd(9'h181);
            check("assign", v, 8'(c));
        end
    endtask : t_presc

    task automatic t_wdog;
        for (int c = 0; c < 2; c++) begin
            wr(9'h181, c ? 8'h09 : 8'h00);
            @(posedge clk);
            wd_clr <= 1'b1;
            @(posedge clk);
            wd_clr <= 1'b0;
            #1 ticks = 0;
            repeat (256) @(posedge clk);
            e = c ? 32 : 64;
            check("wd ticks", 8'(ticks >= e - 1 && ticks <= e + 1), 8'h01);
        end
    endtask : t_wdog

    task automatic t_ext;
        logic [7:0] exp[4] = '{8'h01, 8'h01, 8'h01, 8'h02};
        wr(9'h181, 8'h28);
        wr(9'h101, 8'h00);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) wr(9'h181, 8'h38);
            tmr_pins_model_i.drive(!k[0], 1'b0, 4'h0);
            rd(9'h101);
            check("ext count", v, exp[k]);
        end
    endtask : t_ext

    task automatic t_int;
        wr(9'h10b, 8'h00);
        wr(9'h181, 8'h48);
        tmr_pins_model_i.drive(1'b0, 1'b1, 4'h0);
        rd(9'h10b);
        check("pin rise", v & 8'h02, 8'h02);
        wr(9'h181, 8'h08);
        wr(9'h10b, 8'h00);
        tmr_pins_model_i.drive(1'b0, 1'b0, 4'h0);
        rd(9'h10b);
        check("pin fall", v & 8'h02, 8'h02);
        wr(9'h10b, 8'h92);
        @(posedge clk);
        check("irq", {7'h00, irq}, 8'h01);
        wr(9'h10b, 8'h00);
        tmr_pins_model_i.drive(1'b0, 1'b1, 4'h0);
        rd(9'h10b);
        check("wrong edge", v & 8'h02, 8'h00);
    endtask : t_int

    task automatic t_port;
        tmr_pins_model_i.drive(1'b0, 1'b1, 4'h5);
        rd(9'h10b);
        check("port flag", v & 8'h01, 8'h01);
        @(posedge clk);
        port_rd <= 1'b1;
        @(posedge clk);
        port_rd <= 1'b0;
        wr(9'h10b, 8'h00);
        rd(9'h10b);
        check("port clear", v & 8'h01, 8'h00);
    endtask : t_port

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_regs();
        t_ovf();
        t_presc();
        t_wdog();
        t_ext();
        t_int();
        t_port();
        give_verdict();
    end

    // About five times the expected run length
    initial begin
        #35000;
        bad_count++;
        give_verdict();
    end
endmodule : tmr_timer0_tb
